/* File: verilog/sls_pkg.sv */
// shared constants for the status indicator block
package sls_pkg;

  // ------------------------------------------------------------
  // clock and time base
  // ------------------------------------------------------------
  localparam int CLK_HZ          = 40_000_000;
  localparam int FLICKER_HALF_MS = 50;
  localparam int BLINK_HALF_MS   = 200;
  localparam int FLASH_ON_MS     = 200;
  localparam int FLASH_GAP_MS    = 200;
  localparam int FLASH_PAUSE_MS  = 1000;
  localparam int HB_PERIOD_MS    = 1000;
  localparam int HB_ON_MS        = 100;

  // one tick is one flicker half period
  localparam int TICK_MS  = FLICKER_HALF_MS;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;

  // ------------------------------------------------------------
  // pattern lengths in ticks
  // ------------------------------------------------------------
  localparam int TMR_W = 5;
  localparam logic [TMR_W-1:0] BLINK_TICKS     = TMR_W'(BLINK_HALF_MS / TICK_MS);
  localparam logic [TMR_W-1:0] FLASH_ON_TICKS  = TMR_W'(FLASH_ON_MS / TICK_MS);
  localparam logic [TMR_W-1:0] FLASH_GAP_TICKS = TMR_W'(FLASH_GAP_MS / TICK_MS);
  localparam logic [TMR_W-1:0] PAUSE_TICKS     = TMR_W'(FLASH_PAUSE_MS / TICK_MS);
  localparam logic [TMR_W-1:0] HB_PERIOD_TICKS = TMR_W'(HB_PERIOD_MS / TICK_MS);
  localparam logic [TMR_W-1:0] HB_ON_TICKS     = TMR_W'(HB_ON_MS / TICK_MS);
  localparam logic [1:0]       WARM_DONE       = 2'h3;

  // ------------------------------------------------------------
  // error classes, shown as flash counts
  // ------------------------------------------------------------
  localparam logic [2:0] ERR_CLS_GENERAL = 3'h1;
  localparam logic [2:0] ERR_CLS_VOLTAGE = 3'h2;
  localparam logic [2:0] ERR_CLS_TEMP    = 3'h3;
  localparam logic [2:0] ERR_CLS_OVERCUR = 3'h4;
  localparam logic [2:0] ERR_CLS_CTRL    = 3'h5;
  localparam logic [2:0] ERR_CLS_WDOG    = 3'h6;

  // ------------------------------------------------------------
  // bus slave states
  // ------------------------------------------------------------
  localparam logic [2:0] BUS_ST_STARTUP = 3'h0;
  localparam logic [2:0] BUS_ST_INIT    = 3'h1;
  localparam logic [2:0] BUS_ST_PREOP   = 3'h2;
  localparam logic [2:0] BUS_ST_SAFEOP  = 3'h3;
  localparam logic [2:0] BUS_ST_OP      = 3'h4;
  localparam logic [2:0] BUS_ST_BOOT    = 3'h5;

  // ------------------------------------------------------------
  // bus fault causes
  // ------------------------------------------------------------
  localparam logic [2:0] FLT_NONE  = 3'h0;
  localparam logic [2:0] FLT_CFG   = 3'h1;
  localparam logic [2:0] FLT_LOCAL = 3'h2;
  localparam logic [2:0] FLT_WDOG  = 3'h3;
  localparam logic [2:0] FLT_APP   = 3'h4;
  localparam logic [2:0] FLT_BOOT  = 3'h5;
  localparam logic [2:0] FLT_CTRL  = 3'h6;

endpackage : sls_pkg

/* File: verilog/sls_sync2.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sls_sync2
  import sls_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  // data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sls_sync_st_t;

  sls_sync_st_t s_q;
  sls_sync_st_t s_d;

  always_comb begin
    s_d        = s_q;
    s_d.meta   = async_i;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.stable;

endmodule : sls_sync2
`default_nettype wire

/* File: verilog/sls_flash_burst.sv */
// repeating burst of n flashes followed by a long pause
`timescale 1ns/1ps
`default_nettype none
module sls_flash_burst
  import sls_pkg::*;
#(
  parameter int CNT_W = 3
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  // pattern control
  input  wire logic             tick_i,
  input  wire logic [CNT_W-1:0] count_i,
  // indicator
  output logic                  led_o
);

  typedef enum logic [1:0] {FB_ON, FB_GAP, FB_PAUSE} sls_fb_state_t;

  typedef struct packed {
    sls_fb_state_t    st;
    logic [TMR_W-1:0] tmr;
    logic [CNT_W-1:0] left;
    logic             led;
  } sls_fb_st_t;

  sls_fb_st_t s_q;
  sls_fb_st_t s_d;

  // ------------------------------------------------------------
  // sequencer; count is latched at burst start
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (tick_i) begin
      if (s_q.tmr != '0) begin
        s_d.tmr = s_q.tmr - 1'b1;
      end else begin
        unique case (s_q.st)
          FB_PAUSE: begin
            if (count_i != '0) begin
              s_d.st   = FB_ON;
              s_d.tmr  = FLASH_ON_TICKS - 1'b1;
              s_d.left = count_i - 1'b1;
            end
          end
          FB_ON: begin
            if (s_q.left == '0) begin
              s_d.st  = FB_PAUSE;
              s_d.tmr = PAUSE_TICKS - 1'b1;
            end else begin
              s_d.st  = FB_GAP;
              s_d.tmr = FLASH_GAP_TICKS - 1'b1;
            end
          end
          FB_GAP: begin
            s_d.st   = FB_ON;
            s_d.tmr  = FLASH_ON_TICKS - 1'b1;
            s_d.left = s_q.left - 1'b1;
          end
          default: begin
            s_d.st  = FB_PAUSE;
            s_d.tmr = '0;
          end
        endcase
      end
    end
    s_d.led = (s_d.st == FB_ON);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '{st: FB_PAUSE, tmr: '0, left: '0, led: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign led_o = s_q.led;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_flash_on_tick: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $changed(led_o) |-> $past(tick_i))
    else $error("flash output changed off tick");

  chk_flash_on_len: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (s_q.st == FB_ON) |-> (s_q.tmr < FLASH_ON_TICKS) && led_o)
    else $error("flash on phase too long");

endmodule : sls_flash_burst
`default_nettype wire

/* File: verilog/sls_status_led.sv */
// status indicator logic: power, link, bus state and bus fault
// Notes on behaviour
// - with no error active the power indicator gives a short green pulse once every second.
// - with an error active the power indicator is red and repeats bursts of as many flashes as the class number.
// - classes map to counts 1 general, 2 voltage, 3 temperature, 4 overcurrent, 5 controller, 6 watchdog reset.
// - every raised error also stores its detailed code in the error history object.
// - the link indicator is lit while the cable is connected and flickers while frames move.
// - bus state indicator is off in INIT, blinking in PRE-OP, single flash in SAFE-OP, lit in OP.
// - bus state indicator flickers while starting up before INIT and in bootloader mode.
// - fault indicator: off no error, blink bad config, double flash watchdog timeout, flicker boot failure.
// - fault indicator single flash when the slave left its bus state on its own due to a local error.
// - fault indicator triple flash on application error and steady on controller failure.
`timescale 1ns/1ps
`default_nettype none
module sls_status_led
  import sls_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int CODE_W      = 16,
  parameter int HIST_DEPTH  = 8,
  parameter int HIW         = $clog2(HIST_DEPTH)
) (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // error reports
  input  wire logic              err_raise_i,
  input  wire logic [2:0]        err_class_i,
  input  wire logic [CODE_W-1:0] err_code_i,
  input  wire logic              err_clear_i,
  // error history object
  input  wire logic [HIW-1:0]    hist_rd_idx_i,
  output logic      [CODE_W-1:0] hist_rd_code_o,
  output logic      [CODE_W-1:0] hist_last_code_o,
  output logic      [HIW-1:0]    hist_wr_ptr_o,
  output logic                   err_active_o,
  output logic      [2:0]        err_class_o,
  // bus status
  input  wire logic [2:0]        bus_state_i,
  input  wire logic [2:0]        fault_cause_i,
  // link pins
  input  wire logic              link_up_i,
  input  wire logic              link_act_i,
  // indicators
  output logic                   power_green_o,
  output logic                   power_red_o,
  output logic                   link_indicator_o,
  output logic                   bus_state_indicator_o,
  output logic                   bus_fault_indicator_o
);

  localparam int TCW = $clog2(TICK_CYCLES + 1);

  typedef struct packed {
    logic [TCW-1:0]                   tick_cnt;
    logic                             tick;
    logic                             flicker;
    logic [TMR_W-1:0]                 blink_cnt;
    logic                             blink;
    logic [TMR_W-1:0]                 hb_cnt;
    logic                             err_active;
    logic [2:0]                       err_class;
    logic [HIST_DEPTH-1:0][CODE_W-1:0] hist;
    logic [HIW-1:0]                   wr_ptr;
    logic [CODE_W-1:0]                last_code;
    logic [CODE_W-1:0]                rd_code;
    logic [2:0]                       bus_st;
    logic [2:0]                       fault;
    logic                             act_seen;
    logic                             act_busy;
    logic [1:0]                       warm;
    logic                             led_pwr_g;
    logic                             led_pwr_r;
    logic                             led_link;
    logic                             led_bus;
    logic                             led_fault;
  } sls_top_st_t;

  sls_top_st_t s_q;
  sls_top_st_t s_d;

  logic [1:0] pin_sync;
  logic       link_up_s;
  logic       link_act_s;
  logic [2:0] pwr_num;
  logic [2:0] bus_num;
  logic [2:0] fault_num;
  logic       pwr_burst;
  logic       bus_burst;
  logic       fault_burst;
  logic [2:0] cls_norm;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  sls_sync2 #(
    .W (2)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    ({link_act_i, link_up_i}),
    .sync_o     (pin_sync)
  );

  assign link_up_s  = pin_sync[0];
  assign link_act_s = pin_sync[1];

  // ------------------------------------------------------------
  // flash burst generators
  // ------------------------------------------------------------
  assign pwr_num = s_q.err_active ? s_q.err_class : 3'h0;
  assign bus_num = (s_q.bus_st == BUS_ST_SAFEOP) ? 3'h1 : 3'h0;

  always_comb begin
    fault_num = 3'h0;
    if (s_q.fault == FLT_LOCAL) begin
      fault_num = 3'h1;
    end else if (s_q.fault == FLT_WDOG) begin
      fault_num = 3'h2;
    end else if (s_q.fault == FLT_APP) begin
      fault_num = 3'h3;
    end
  end

  sls_flash_burst #(
    .CNT_W (3)
  ) u_pwr_burst (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tick_i     (s_q.tick),
    .count_i    (pwr_num),
    .led_o      (pwr_burst)
  );

  sls_flash_burst #(
    .CNT_W (3)
  ) u_bus_burst (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tick_i     (s_q.tick),
    .count_i    (bus_num),
    .led_o      (bus_burst)
  );

  sls_flash_burst #(
    .CNT_W (3)
  ) u_fault_burst (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tick_i     (s_q.tick),
    .count_i    (fault_num),
    .led_o      (fault_burst)
  );

  // ------------------------------------------------------------
  // class decode, unknown codes count as general
  // ------------------------------------------------------------
  assign cls_norm = (err_class_i >= ERR_CLS_GENERAL && err_class_i <= ERR_CLS_WDOG) ?
                    err_class_i : ERR_CLS_GENERAL;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // time base
    if (s_q.tick_cnt == TCW'(TICK_CYCLES - 1)) begin
      s_d.tick_cnt = '0;
      s_d.tick     = 1'b1;
    end else begin
      s_d.tick_cnt = TCW'(s_q.tick_cnt + 1'b1);
      s_d.tick     = 1'b0;
    end
    if (s_q.tick) begin
      s_d.flicker = ~s_q.flicker;
      if (s_q.blink_cnt == BLINK_TICKS - 1'b1) begin
        s_d.blink_cnt = '0;
        s_d.blink     = ~s_q.blink;
      end else begin
        s_d.blink_cnt = s_q.blink_cnt + 1'b1;
      end
      if (s_q.hb_cnt == HB_PERIOD_TICKS - 1'b1) begin
        s_d.hb_cnt = '0;
      end else begin
        s_d.hb_cnt = s_q.hb_cnt + 1'b1;
      end
    end
    // error tracking, a raise beats a clear
    if (err_raise_i) begin
      s_d.err_active          = 1'b1;
      s_d.err_class           = cls_norm;
      s_d.hist[s_q.wr_ptr]    = err_code_i;
      s_d.last_code           = err_code_i;
      s_d.wr_ptr              = (s_q.wr_ptr == HIW'(HIST_DEPTH - 1)) ? '0 : HIW'(s_q.wr_ptr + 1'b1);
    end else if (err_clear_i) begin
      s_d.err_active = 1'b0;
    end
    s_d.rd_code = s_q.hist[hist_rd_idx_i];
    // status capture
    s_d.bus_st = bus_state_i;
    s_d.fault  = fault_cause_i;
    if (s_q.warm != WARM_DONE) begin
      s_d.warm = s_q.warm + 1'b1;
    end
    // activity window of at least one tick
    if (s_q.tick) begin
      s_d.act_busy = s_q.act_seen | link_act_s;
      s_d.act_seen = link_act_s;
    end else if (link_act_s) begin
      s_d.act_seen = 1'b1;
    end
    // indicators
    s_d.led_pwr_g = !s_q.err_active && (s_q.hb_cnt < HB_ON_TICKS);
    s_d.led_pwr_r = s_q.err_active && pwr_burst;
    s_d.led_link  = link_up_s && (!s_q.act_busy || s_q.flicker);
    unique case (s_q.bus_st)
      BUS_ST_INIT:    s_d.led_bus = 1'b0;
      BUS_ST_PREOP:   s_d.led_bus = s_q.blink;
      BUS_ST_SAFEOP:  s_d.led_bus = bus_burst;
      BUS_ST_OP:      s_d.led_bus = 1'b1;
      BUS_ST_STARTUP,
      BUS_ST_BOOT:    s_d.led_bus = s_q.flicker;
      default:        s_d.led_bus = s_q.flicker;
    endcase
    unique case (s_q.fault)
      FLT_NONE:   s_d.led_fault = 1'b0;
      FLT_CFG:    s_d.led_fault = s_q.blink;
      FLT_LOCAL,
      FLT_WDOG,
      FLT_APP:    s_d.led_fault = fault_burst;
      FLT_BOOT:   s_d.led_fault = s_q.flicker;
      FLT_CTRL:   s_d.led_fault = 1'b1;
      default:    s_d.led_fault = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign hist_rd_code_o        = s_q.rd_code;
  assign hist_last_code_o      = s_q.last_code;
  assign hist_wr_ptr_o         = s_q.wr_ptr;
  assign err_active_o          = s_q.err_active;
  assign err_class_o           = s_q.err_class;
  assign power_green_o         = s_q.led_pwr_g;
  assign power_red_o           = s_q.led_pwr_r;
  assign link_indicator_o      = s_q.led_link;
  assign bus_state_indicator_o = s_q.led_bus;
  assign bus_fault_indicator_o = s_q.led_fault;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  chk_green_off_err: assert property ($past(s_q.err_active) |-> !power_green_o)
    else $error("green heartbeat while error active");

  chk_green_hb_slot: assert property (power_green_o |-> $past(s_q.hb_cnt) < HB_ON_TICKS)
    else $error("green outside heartbeat slot");

  chk_red_needs_err: assert property (power_red_o |-> $past(s_q.err_active))
    else $error("red without error");

  chk_raise_beats_clr: assert property (err_raise_i && err_clear_i |=> s_q.err_active)
    else $error("clear won over raise");

  chk_class_decode: assert property (err_raise_i |=>
    s_q.err_class == (($past(err_class_i) >= ERR_CLS_GENERAL && $past(err_class_i) <= ERR_CLS_WDOG) ?
                      $past(err_class_i) : ERR_CLS_GENERAL))
    else $error("error class decoded wrong");

  chk_hist_store: assert property (err_raise_i |=>
    (s_q.last_code == $past(err_code_i)) && (s_q.hist[$past(s_q.wr_ptr)] == $past(err_code_i)))
    else $error("error code not stored");

  chk_link_unplug: assert property ((s_q.warm == WARM_DONE) && !$past(link_up_i, 3)
    |-> !link_indicator_o)
    else $error("link lit without cable");

  chk_bus_op_lit: assert property ((s_q.warm == WARM_DONE) && ($past(bus_state_i, 2) == BUS_ST_OP)
    |-> bus_state_indicator_o)
    else $error("bus state dark in operational");

  chk_bus_init_dark: assert property ((s_q.warm == WARM_DONE) && ($past(bus_state_i, 2) == BUS_ST_INIT)
    |-> !bus_state_indicator_o)
    else $error("bus state lit in init");

  chk_bus_boot_flick: assert property ((s_q.bus_st == BUS_ST_BOOT)
    |=> (bus_state_indicator_o == $past(s_q.flicker)))
    else $error("bus state not flickering in boot");

  chk_fault_none: assert property ((s_q.warm == WARM_DONE) && ($past(fault_cause_i, 2) == FLT_NONE)
    |-> !bus_fault_indicator_o)
    else $error("fault lit with no fault");

  chk_fault_cfg_blink: assert property ((s_q.fault == FLT_CFG)
    |=> (bus_fault_indicator_o == $past(s_q.blink)))
    else $error("fault not blinking on bad config");

  chk_fault_local_one: assert property ((s_q.fault == FLT_LOCAL) |-> (fault_num == 3'h1)
    ##1 (bus_fault_indicator_o == $past(fault_burst)))
    else $error("local error not single flash");

  chk_fault_ctrl_red: assert property ((s_q.warm == WARM_DONE) && ($past(fault_cause_i, 2) == FLT_CTRL)
    |-> bus_fault_indicator_o)
    else $error("fault dark on controller failure");

  chk_flicker_tick: assert property ($changed(s_q.flicker) |-> $past(s_q.tick))
    else $error("flicker changed off tick");

  cov_red_burst: cover property ($rose(power_red_o));
  cov_bus_op: cover property ((s_q.bus_st == BUS_ST_OP) ##1 bus_state_indicator_o);
  cov_wdog_flash: cover property ((s_q.fault == FLT_WDOG) && $rose(bus_fault_indicator_o));
  cov_link_busy: cover property ($rose(s_q.act_busy));

endmodule : sls_status_led
`default_nettype wire

/* File: verif/sls_observer.sv */
// observer model: watches one indicator the way a person reads it
`timescale 1ns/1ps
`default_nettype none
module sls_observer (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // indicator under watch
  input  wire logic        led_i,
  // what was seen
  output logic      [15:0] rises_o,
  output logic      [15:0] hi_len_o,
  output logic      [15:0] burst_o
);
  logic        prev_q;
  logic [15:0] hi_q;
  logic [15:0] lo_q;
  logic [15:0] cnt_q;

  // ------------------------------------------------------------
  // pulse lengths and flash bursts
  // ------------------------------------------------------------
  // a dark run of 40 cycles (10 ticks) closes a burst of flashes
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_q   <= 1'b0;
      hi_q     <= 16'h0000;
      lo_q     <= 16'h0000;
      cnt_q    <= 16'h0000;
      rises_o  <= 16'h0000;
      hi_len_o <= 16'h0000;
      burst_o  <= 16'h0000;
    end else begin
      prev_q <= led_i;
      if (led_i) begin
        lo_q <= 16'h0000;
        hi_q <= prev_q ? hi_q + 16'h0001 : 16'h0001;
        if (!prev_q) begin
          rises_o <= rises_o + 16'h0001;
          cnt_q   <= cnt_q + 16'h0001;
        end
      end else begin
        if (prev_q) begin
          hi_len_o <= hi_q;
        end
        if (lo_q != 16'hFFFF) begin
          lo_q <= lo_q + 16'h0001;
        end
        if (lo_q == 16'h0027) begin
          burst_o <= cnt_q;
          cnt_q   <= 16'h0000;
        end
      end
    end
  end
endmodule : sls_observer
`default_nettype wire

/* File: verif/sls_status_led_bench.sv */
// self-checking testbench for the status indicator block
`timescale 1ns/1ps
`default_nettype none
module sls_status_led_bench;
  import sls_pkg::*;
  localparam int TCY   = 4;
  localparam int LIMIT = 30000;

  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic        core_clk_i    = 1'b0;
  logic        rst_i         = 1'b1;
  logic        err_raise_i   = 1'b0;
  logic [2:0]  err_class_i   = 3'h0;
  logic [15:0] err_code_i    = 16'h0000;
  logic        err_clear_i   = 1'b0;
  logic [2:0]  hist_rd_idx_i = 3'h0;
  logic [2:0]  bus_state_i   = BUS_ST_STARTUP;
  logic [2:0]  fault_cause_i = FLT_NONE;
  logic        link_up_i     = 1'b0;
  logic        link_act_i    = 1'b0;
  logic [15:0] rd_code;
  logic [15:0] last_code;
  logic [2:0]  wr_ptr;
  logic        active;
  logic [2:0]  cls;
  logic [4:0]  leds;
  logic [15:0] rises  [5];
  logic [15:0] hi_len [5];
  logic [15:0] burst  [5];
  int          fails     = 0;
  int          tests_run = 0;
  int          cycles    = 0;

  always #12.5 core_clk_i = ~core_clk_i;

  sls_status_led #(.TICK_CYCLES(TCY)) dut_u (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .err_raise_i(err_raise_i), .err_class_i(err_class_i),
    .err_code_i(err_code_i), .err_clear_i(err_clear_i), .hist_rd_idx_i(hist_rd_idx_i),
    .hist_rd_code_o(rd_code), .hist_last_code_o(last_code), .hist_wr_ptr_o(wr_ptr),
    .err_active_o(active), .err_class_o(cls), .bus_state_i(bus_state_i), .fault_cause_i(fault_cause_i),
    .link_up_i(link_up_i), .link_act_i(link_act_i), .power_green_o(leds[0]), .power_red_o(leds[1]),
    .link_indicator_o(leds[2]), .bus_state_indicator_o(leds[3]), .bus_fault_indicator_o(leds[4]));

  // 0 green, 1 red, 2 link, 3 bus state, 4 bus fault
  for (genvar g = 0; g < 5; g++) begin : g_obs
    sls_observer obs_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .led_i(leds[g]),
                        .rises_o(rises[g]), .hi_len_o(hi_len[g]), .burst_o(burst[g]));
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      end_sim();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask : cyc

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check

  // kind 0 dark, 1 lit, 2 pulses of n cycles, 3 bursts of n flashes
  task automatic check_led(input int idx, input int kind, input int n);
    logic [15:0] r0;
    cyc(400);
    r0 = rises[idx];
    cyc(100);
    if (kind < 2) begin
      check(leds[idx], kind);
      check(rises[idx] - r0, 0);
    end else if (kind == 2) begin
      check(hi_len[idx], n);
    end else begin
      check(burst[idx], n);
      check(hi_len[idx], 16);
    end
  endtask : check_led

  task automatic raise(input logic [2:0] c, input logic [15:0] code, input logic clr);
    err_raise_i = 1'b1;
    err_class_i = c;
    err_code_i  = code;
    err_clear_i = clr;
    cyc(1);
    err_raise_i = 1'b0;
    err_clear_i = 1'b0;
  endtask : raise

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_heartbeat();
    logic [15:0] r0;
    cyc(40);
    r0 = rises[0];
    cyc(800);
    check(rises[0] - r0, 10);
    check(hi_len[0], 8);
    check(rises[1], 0);
    $display("heartbeat done");
  endtask : test_heartbeat

  task automatic test_errors();
    logic [15:0] r0;
    for (int i = 0; i < 6; i++) begin
      raise(3'(i + 1), 16'hA000 + 16'(i), 1'b0);
      check(active, 1);
      check(cls, i + 1);
      check(last_code, 16'hA000 + 16'(i));
      check(wr_ptr, i + 1);
      cyc(600);
      r0 = rises[0];
      cyc(100);
      check(burst[1], i + 1);
      check(rises[0] - r0, 0);
    end
    raise(3'h0, 16'hA006, 1'b0);
    cyc(1);
    raise(3'h7, 16'hA007, 1'b1);
    check(cls, 1);
    check(active, 1);
    check(wr_ptr, 0);
    cyc(1);
    err_clear_i = 1'b1;
    cyc(1);
    err_clear_i = 1'b0;
    check(active, 0);
    for (int i = 0; i < 8; i++) begin
      hist_rd_idx_i = 3'(i);
      cyc(1);
      check(rd_code, 16'hA000 + 16'(i));
    end
    check_led(1, 0, 0);
    check(hi_len[0], 8);
    $display("error classes done");
  endtask : test_errors

  task automatic test_bus_state();
    logic [2:0] st [6] = '{BUS_ST_STARTUP, BUS_ST_INIT, BUS_ST_PREOP, BUS_ST_SAFEOP, BUS_ST_OP, BUS_ST_BOOT};
    int         kd [6] = '{2, 0, 2, 3, 1, 2};
    int         nn [6] = '{4, 0, 16, 1, 0, 4};
    for (int i = 0; i < 6; i++) begin
      bus_state_i = st[i];
      check_led(3, kd[i], nn[i]);
    end
    $display("bus state done");
  endtask : test_bus_state

  task automatic test_fault();
    int kd [7] = '{0, 2, 3, 3, 3, 2, 1};
    int nn [7] = '{0, 16, 1, 2, 3, 4, 0};
    for (int i = 0; i < 7; i++) begin
      fault_cause_i = 3'(i);
      check_led(4, kd[i], nn[i]);
    end
    fault_cause_i = FLT_NONE;
    $display("bus fault done");
  endtask : test_fault

  task automatic test_link();
    logic [15:0] r0;
    check_led(2, 0, 0);
    link_up_i = 1'b1;
    check_led(2, 1, 0);
    r0 = rises[2];
    for (int i = 0; i < 60; i++) begin
      link_act_i = ~link_act_i;
      cyc(5);
    end
    link_act_i = 1'b0;
    check((rises[2] - r0) > 16'h0005, 1);
    check_led(2, 1, 0);
    $display("link done");
  endtask : test_link

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    cyc(20);
    rst_i = 1'b0;
    cyc(2);
    test_heartbeat();
    test_errors();
    test_bus_state();
    test_fault();
    test_link();
    end_sim();
  end
endmodule : sls_status_led_bench
`default_nettype wire
